/* File: hw/ebat_access.sv */
`timescale 1ns/10ps
`default_nettype none

module ebat_access
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // boot strap
    input  wire logic               boot_width_select,
    // chip select configuration
    input  wire logic               cfg_write,
    input  wire logic [2:0]         cfg_sel,
    input  wire ebat_pkg::ebat_cfg_t cfg_data,
    input  wire logic               remap,
    // memory control
    input  wire logic               mc_write,
    input  wire logic               read_protocol_select,
    // processor side requests
    input  wire logic               req_valid,
    input  wire ebat_pkg::ebat_req_t req,
    output logic                    req_done,
    output logic [15:0]             req_rdata,
    // external bus
    output logic [23:0]             ext_addr,
    output logic [7:0]              chip_select_n,
    output logic                    read_strobe_n,
    output logic                    low_byte_write_n,
    output logic                    high_byte_write_n,
    input  wire logic [15:0]        data_in,
    output logic [15:0]             data_out,
    output logic                    data_oe_n,
    input  wire logic               wait_request_n,
    // status
    output logic [11:0]             cs0_base_active,
    output logic [1:0]              cs0_width,
    output logic                    busy
);

    // ------------------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------------------
    ebat_pkg::ebat_cfg_t   cfg [ebat_pkg::NUM_CS];    // chip select table
    logic                  boot_done;                 // strap taken
    logic                  proto;                     // global read protocol
    ebat_pkg::ebat_state_t state;                     // sequencer state
    ebat_pkg::ebat_state_t next_state;                // its next value
    ebat_pkg::ebat_req_t   cur;                       // access in flight
    ebat_pkg::ebat_req_t   next_cur;                  // request to present
    logic [3:0]            rem;                       // wait cycles left
    logic [3:0]            wtot;                      // waits of this access
    logic [2:0]            float_cnt;                 // pending float time
    logic                  last_valid;                // an external access ran
    logic [2:0]            last_cs;                   // its chip select
    logic                  last_write;                // it was a write, with no internal access since
    logic                  pend_early;                // early read wait owed
    logic                  pend_cs;                   // select change owed
    logic                  take;                      // request accepted
    logic                  finish;                    // external access ends
    logic                  chain;                     // same memory read follows
    logic                  stall;                     // wait request seen
    logic                  need_float;                // incoming needs float
    logic                  need_early;                // incoming needs early wait
    logic                  need_cs;                   // incoming changes memory
    // strobe shaping flops and the write strobe gate
    logic                  win_rd;                    // read window, rising edge
    logic                  win_wr;                    // write window, rising edge
    logic                  rd_early;                  // early read strobe
    logic                  win_bat;                   // access type of window
    logic [1:0]            win_be;                    // byte lanes of window
    logic                  rd_neg;                    // read half, falling edge
    logic                  wr_neg;                    // write half, falling edge
    logic                  wlow;                      // write strobe active

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // standard wait cycles of one chip select
    function automatic logic [3:0] wait_cycles(input ebat_pkg::ebat_cfg_t c);
        logic [3:0] n;
        n = {1'b0, c.wait_count} + ebat_pkg::ONE_WAIT;
        return c.wait_enable ? n : ebat_pkg::NO_WAITS;
    endfunction

    // the pin is sampled straight on the rising edge, no filtering
    assign stall = ~wait_request_n;

    // ------------------------------------------------------------------------
    // configuration table
    // ------------------------------------------------------------------------
    // boot values land under reset; the width strap is taken on the first
    // edge after release, since an async reset may only load constants
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < ebat_pkg::NUM_CS; i++)
            begin
                cfg[i] <= '0;
                cfg[i].base <= 12'(ebat_pkg::CS_BASE_STEP * i);
            end
            cfg[0].base        <= ebat_pkg::CS0_BASE_RESET;
            cfg[0].wait_enable <= ebat_pkg::BOOT_WAIT_ENABLE;
            cfg[0].wait_count  <= ebat_pkg::BOOT_WAIT_COUNT;
            cfg[0].bat         <= ebat_pkg::BAT_BYTE_WRITE;
            cfg[0].float_time  <= ebat_pkg::BOOT_FLOAT_TIME;
            cfg[0].dbw         <= ebat_pkg::DBW_16;
            boot_done          <= 1'b0;
        end
        else
        begin
            boot_done <= 1'b1;
            if (cfg_write)
                cfg[cfg_sel] <= cfg_data;
            else if (!boot_done)
                cfg[0].dbw <= boot_width_select ? ebat_pkg::DBW_8
                                                : ebat_pkg::DBW_16;
        end
    end

    // cs0 decoding base only moves on remap; its waits act at once
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cs0_base_active <= ebat_pkg::CS0_BASE_RESET;
        else if (remap)
            cs0_base_active <= cfg[0].base;
    end

    // width readback
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cs0_width <= ebat_pkg::DBW_16;
        else
            cs0_width <= cfg[0].dbw;
    end

    // one global protocol bit for every memory
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            proto <= ebat_pkg::PROTO_STANDARD;
        else if (mc_write)
            proto <= read_protocol_select;
    end

    // ------------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------------
    // what an incoming external request owes before its access
    always_comb
    begin
        need_float = (float_cnt != 3'h0) &&
                     (req.write || req.cs != last_cs);
        need_early = (proto == ebat_pkg::PROTO_EARLY) &&
                     !req.write && last_write;
        need_cs    = last_valid && (req.cs != last_cs);
    end

    // next state; a frozen access holds everything
    always_comb
    begin
        next_state = state;
        take       = 1'b0;
        finish     = (state == ebat_pkg::S_ACCESS) && !stall && (rem == 4'h0);
        chain      = finish && req_valid && !req.internal && !req.write &&
                     !cur.write && (req.cs == cur.cs);
        case (state)
            ebat_pkg::S_IDLE:
            begin
                if (req_valid)
                begin
                    take = 1'b1;
                    // internal work never waits on the external bus
                    if (req.internal)
                        next_state = ebat_pkg::S_IDLE;
                    else if (need_float)
                        next_state = ebat_pkg::S_FLOAT;
                    else if (need_early)
                        next_state = ebat_pkg::S_EARLY;
                    else if (need_cs)
                        next_state = ebat_pkg::S_CSCHG;
                    else
                        next_state = ebat_pkg::S_ACCESS;
                end
            end
            ebat_pkg::S_FLOAT:
            begin
                // float counts as a wait, so no select change follows
                if (float_cnt == 3'h0)
                    next_state = pend_early ? ebat_pkg::S_EARLY
                                            : ebat_pkg::S_ACCESS;
            end
            ebat_pkg::S_EARLY:
                next_state = ebat_pkg::S_ACCESS;
            ebat_pkg::S_CSCHG:
                next_state = ebat_pkg::S_ACCESS;
            ebat_pkg::S_ACCESS:
            begin
                if (chain)
                begin
                    take       = 1'b1;
                    next_state = ebat_pkg::S_ACCESS;
                end
                else if (finish)
                    next_state = ebat_pkg::S_IDLE;
            end
            default:
                next_state = ebat_pkg::S_IDLE;
        endcase
        next_cur = take ? req : cur;
    end

    // state register
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state <= ebat_pkg::S_IDLE;
        else
            state <= next_state;
    end

    // request latch and owed waits
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cur        <= '0;
            pend_early <= 1'b0;
            pend_cs    <= 1'b0;
        end
        else if (take)
        begin
            cur        <= req;
            pend_early <= need_early;
            pend_cs    <= need_cs;
        end
    end

    // wait counter: loaded on entry, frozen by the wait request
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rem  <= ebat_pkg::NO_WAITS;
            wtot <= ebat_pkg::NO_WAITS;
        end
        else if (next_state == ebat_pkg::S_ACCESS &&
                 (state != ebat_pkg::S_ACCESS || chain))
        begin
            rem  <= wait_cycles(cfg[next_cur.cs]);
            wtot <= wait_cycles(cfg[next_cur.cs]);
        end
        else if (state == ebat_pkg::S_ACCESS && !stall && rem != 4'h0)
            rem <= rem - 4'h1;
    end

    // history of the last external access and its float time; float runs
    // down in every state, so internal accesses overlap it
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            float_cnt  <= 3'h0;
            last_valid <= 1'b0;
            last_cs    <= 3'h0;
            last_write <= 1'b0;
        end
        else if (finish)
        begin
            float_cnt  <= cur.write ? 3'h0 : cfg[cur.cs].float_time;
            last_valid <= 1'b1;
            last_cs    <= cur.cs;
            last_write <= cur.write;
        end
        else
        begin
            if (float_cnt != 3'h0)
                float_cnt <= float_cnt - 3'h1;
            if (take && req.internal)
                last_write <= 1'b0;
        end
    end

    // processor side answer
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            req_done  <= 1'b0;
            req_rdata <= 16'h0000;
            busy      <= 1'b0;
        end
        else
        begin
            req_done <= finish || (take && req.internal);
            busy     <= next_state != ebat_pkg::S_IDLE;
            if (finish && !cur.write)
                req_rdata <= data_in;
        end
    end

    // ------------------------------------------------------------------------
    // external pins, rising edge half
    // ------------------------------------------------------------------------
    // select and address open the access from its first edge
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            chip_select_n <= 8'hff;
            ext_addr      <= 24'h000000;
            data_out      <= 16'h0000;
            win_rd        <= 1'b0;
            win_wr        <= 1'b0;
            rd_early      <= 1'b0;
            win_bat       <= ebat_pkg::BAT_BYTE_WRITE;
            win_be        <= 2'h0;
        end
        else if (!(state == ebat_pkg::S_ACCESS && stall))
        begin
            if (next_state == ebat_pkg::S_ACCESS)
                chip_select_n <= ~(8'h01 << next_cur.cs);
            else
                chip_select_n <= 8'hff;
            ext_addr <= next_cur.addr;
            data_out <= next_cur.wdata;
            win_rd   <= next_state == ebat_pkg::S_ACCESS && !next_cur.write;
            win_wr   <= next_state == ebat_pkg::S_ACCESS && next_cur.write;
            // early strobe stays low across chained same memory reads
            rd_early <= next_state == ebat_pkg::S_ACCESS && !next_cur.write &&
                        proto == ebat_pkg::PROTO_EARLY;
            win_bat  <= cfg[next_cur.cs].bat;
            win_be   <= next_cur.be;
        end
    end

    // ------------------------------------------------------------------------
    // external pins, falling edge half
    // ------------------------------------------------------------------------
    // strobes fall mid cycle; write stays low until mid last cycle, or only
    // the half cycle when no waits are programmed
    always_ff @(negedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_neg    <= 1'b0;
            wr_neg    <= 1'b0;
            data_oe_n <= 1'b1;
        end
        else
        begin
            rd_neg    <= win_rd;
            wr_neg    <= win_wr && (rem != 4'h0 ||
                                    wtot == ebat_pkg::NO_WAITS);
            // drive from the strobe's fall to half a cycle past the fall of win_wr
            data_oe_n <= ~win_wr;
        end
    end

    // strobe pins: the half cycle shapes need both clock edges, so the write strobes gate a rising
    // edge flop with a falling edge one; read_strobe_n also ORs in rd_early, and high_byte_write_n in byte select mode uses rising edge flops only
    assign wlow              = win_wr & wr_neg;
    assign read_strobe_n     = ~(rd_early | (win_rd & rd_neg));
    assign low_byte_write_n  = ~(wlow & (win_bat | win_be[0]));
    assign high_byte_write_n = win_bat ? ~((win_rd | win_wr) & win_be[1])
                                       : ~(wlow & win_be[1]);

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence wr_then_rd;
        state == ebat_pkg::S_IDLE && req_valid && !req.internal &&
        !req.write && last_write && proto == ebat_pkg::PROTO_EARLY &&
        float_cnt == 3'h0;
    endsequence

    sequence early_then_access;
        state == ebat_pkg::S_EARLY ##1 state == ebat_pkg::S_ACCESS;
    endsequence

    AST_BOOT_WAIT: assert property (!boot_done |-> cfg[0].wait_enable &&
        cfg[0].wait_count == ebat_pkg::BOOT_WAIT_COUNT)
        else $error("cs0 boot waits wrong");
    AST_BOOT_WIDTH: assert property (boot_done && !$past(boot_done) &&
        !$past(cfg_write) |=> cs0_width == ($past(boot_width_select, 2)
        ? ebat_pkg::DBW_8 : ebat_pkg::DBW_16))
        else $error("cs0 boot width not from strap");
    AST_BOOT_TYPE: assert property (!boot_done |-> cfg[0].bat ==
        ebat_pkg::BAT_BYTE_WRITE && cfg[0].float_time == 3'h0)
        else $error("cs0 boot access type or float wrong");
    AST_REMAP: assert property (!$past(remap) |-> $stable(cs0_base_active))
        else $error("cs0 base moved without remap");
    AST_PROTO: assert property (!$past(mc_write) |-> $stable(proto))
        else $error("protocol changed without write");
    // half-cycle shapes are checked at the falling edge, whose sampled
    // values are those of the first half of the cycle
    AST_STD_READ: assert property (@(negedge clk) $rose(win_rd) && !rd_early |->
        read_strobe_n && chip_select_n != 8'hff)
        else $error("standard read strobe low at cycle start");
    AST_WRITE_HALF: assert property (@(negedge clk) $rose(win_wr) |-> !wlow)
        else $error("write strobe low at cycle start");
    AST_EARLY_READ: assert property (state == ebat_pkg::S_ACCESS && !cur.write &&
        proto == ebat_pkg::PROTO_EARLY |-> !read_strobe_n)
        else $error("early read strobe not low");
    AST_EARLY_WAIT: assert property (wr_then_rd |=> early_then_access)
        else $error("early read wait missing");
    AST_NO_EARLY: assert property (state == ebat_pkg::S_EARLY |->
        pend_early && !cur.write && !cur.internal)
        else $error("early wait inserted wrongly");
    AST_DATA_HOLD: assert property (@(negedge clk) $fell(win_wr) |->
        !data_oe_n && !wlow)
        else $error("write data released before strobe rose");
    AST_WAIT_LOAD: assert property ($rose(state == ebat_pkg::S_ACCESS)
        && !$past(cfg_write) |-> rem == wait_cycles(cfg[cur.cs]))
        else $error("standard wait count wrong");
    AST_FLOAT_RUN: assert property (state == ebat_pkg::S_IDLE &&
        float_cnt != 3'h0 |=> float_cnt == $past(float_cnt) - 3'h1)
        else $error("float time not counting down");
    AST_STALL: assert property (state == ebat_pkg::S_ACCESS && stall |=>
        state == ebat_pkg::S_ACCESS && $stable(rem) && $stable(chip_select_n))
        else $error("wait request did not freeze access");
    AST_CSCHG: assert property (state == ebat_pkg::S_CSCHG |->
        pend_cs ##1 state == ebat_pkg::S_ACCESS)
        else $error("select change wait not single");

endmodule

`default_nettype wire

/* File: hw/ebat_pkg.sv */
// ----------------------------------------------------------------------------
// shared constants and types of the external access sequencer
// ----------------------------------------------------------------------------
package ebat_pkg;

    // number of chip selects kept in the configuration table
    localparam int          NUM_CS           = 8;

    // data bus width codes
    localparam logic [1:0]  DBW_16           = 2'h1;
    localparam logic [1:0]  DBW_8            = 2'h2;

    // chip select 0 boot configuration and the byte access type codes
    localparam logic        BOOT_WAIT_ENABLE = 1'h1;
    localparam logic [2:0]  BOOT_WAIT_COUNT  = 3'h7;
    localparam logic [2:0]  BOOT_FLOAT_TIME  = 3'h0;
    localparam logic        BAT_BYTE_WRITE   = 1'h0;
    localparam logic        BAT_BYTE_SELECT  = 1'h1;

    // base address reset values, top twelve address bits
    localparam logic [11:0] CS0_BASE_RESET   = 12'h000;
    localparam logic [11:0] CS_BASE_STEP     = 12'h100;

    // global read protocol codes
    localparam logic        PROTO_STANDARD   = 1'h0;
    localparam logic        PROTO_EARLY      = 1'h1;

    // wait cycle count of an access with standard waits disabled, and the one added to a programmed count
    localparam logic [3:0]  NO_WAITS         = 4'h0;
    localparam logic [3:0]  ONE_WAIT         = 4'h1;

    // per chip select configuration
    typedef struct packed {
        logic [11:0] base;
        logic [2:0]  float_time;
        logic        bat;
        logic        wait_enable;
        logic [2:0]  wait_count;
        logic [1:0]  dbw;
    } ebat_cfg_t;

    // one access request from the processor side
    typedef struct packed {
        logic        write;
        logic        internal;
        logic [2:0]  cs;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [1:0]  be;
    } ebat_req_t;

    // sequencer states
    typedef enum {
        S_IDLE,
        S_FLOAT,
        S_EARLY,
        S_CSCHG,
        S_ACCESS
    } ebat_state_t;

endpackage

/* File: bench/ebat_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// external memory seen through the strobes
// ----------------------------------------------------------------
module ebat_mem_model
(
    // pins
    input  wire logic        clk,
    input  wire logic [7:0]  chip_select_n,
    input  wire logic        read_strobe_n,
    input  wire logic [23:0] ext_addr,
    output logic      [15:0] data_in,
    output var logic         wait_request_n,
    // stall cycles for the next access
    input  wire logic [3:0]  stall_req
);
    logic [3:0] left; // stall cycles still owed
    // released bus shows the inverse, never a stale match
    assign data_in = (!read_strobe_n && !(&chip_select_n)) ?
                     (ext_addr[15:0] ^ 16'ha5a5) : ~(ext_addr[15:0] ^ 16'ha5a5);
    initial wait_request_n = 1'h1;
    // assert wait mid first cycle of an access, so it is seen at its first
    // rising edge; release while standard waits remain
    always @(negedge clk)
    begin
        if (&chip_select_n)
        begin
            left <= stall_req;
            wait_request_n <= 1'h1;
        end
        else if (left != 4'h0)
        begin
            wait_request_n <= 1'h0;
            left <= left - 4'h1;
        end
        else
            wait_request_n <= 1'h1;
    end
endmodule
`default_nettype wire

/* File: bench/ebat_access_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ebat_access_tb;
    logic clk = 1'h0, sys_rst = 1'h1, bws = 1'h1, cfg_write = 1'h0, remap = 1'h0;
    logic mc_write = 1'h0, rps = 1'h0, req_valid = 1'h0, req_done, busy, rdn, wrl, wrh, oen;
    logic [2:0] cfg_sel = 3'h0;
    logic [3:0] stall = 4'h0;
    logic [15:0] rdata, din, dout;
    logic [23:0] ext_addr;
    logic [7:0] csn;
    logic [11:0] base0;
    logic [1:0] width0;
    logic wrn;
    ebat_pkg::ebat_cfg_t cfg_data = '0;
    ebat_pkg::ebat_req_t req = '0;
    int failures = 0, n_tests = 0, lat, wlo = 0;
    ebat_access uut (.clk(clk), .sys_rst(sys_rst), .boot_width_select(bws),
        .cfg_write(cfg_write), .cfg_sel(cfg_sel), .cfg_data(cfg_data), .remap(remap),
        .mc_write(mc_write), .read_protocol_select(rps), .req_valid(req_valid), .req(req),
        .req_done(req_done), .req_rdata(rdata), .ext_addr(ext_addr), .chip_select_n(csn),
        .read_strobe_n(rdn), .low_byte_write_n(wrl), .high_byte_write_n(wrh),
        .data_in(din), .data_out(dout), .data_oe_n(oen), .wait_request_n(wrn),
        .cs0_base_active(base0), .cs0_width(width0), .busy(busy));
    ebat_mem_model mem (.clk(clk), .chip_select_n(csn), .read_strobe_n(rdn),
        .ext_addr(ext_addr), .data_in(din), .wait_request_n(wrn), .stall_req(stall));
    initial forever #12.5 clk = ~clk;
    // count write strobe low half cycles, sampled just after each clock edge
    always @(clk)
    begin
        #1;
        if (wrl === 1'h0)
            wlo++;
    end
    task automatic close_out;
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one access, lat = edges up to done, the take edge counted as one
    task automatic acc(input logic wr, input logic in, input logic [2:0] cs);
        wlo = 0;
        @(posedge clk);
        req_valid <= 1'h1;
        req <= '{wr, in, cs, {16'h0012, 5'h0, cs}, 16'h5a3c, 2'h3};
        @(posedge clk);
        req_valid <= 1'h0;
        lat = 1;
        #1;
        while (req_done !== 1'h1 && lat < 40)
        begin
            @(posedge clk);
            #1;
            lat++;
        end
    endtask
    task automatic cfg(input logic [2:0] s, input logic [11:0] b, input logic we,
                       input logic [2:0] n, input logic [2:0] f);
        @(posedge clk);
        cfg_write <= 1'h1;
        cfg_sel <= s;
        cfg_data <= '{b, f, 1'h0, we, n, ebat_pkg::DBW_16};
        @(posedge clk);
        cfg_write <= 1'h0;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        close_out();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (3) @(posedge clk);
        chk({14'h0, width0}, {14'h0, ebat_pkg::DBW_8});
        acc(1'h1, 1'h0, 3'h0);
        acc(1'h1, 1'h0, 3'h0);
        chk(lat[15:0], 16'd10);
        chk(wlo[15:0], 16'd16);
        cfg(3'h0, 12'h0f0, 1'h0, 3'h7, 3'h0);
        acc(1'h1, 1'h0, 3'h0);
        chk(lat[15:0], 16'd2);
        chk(wlo[15:0], 16'd1);
        chk({4'h0, base0}, 16'h0000);
        @(posedge clk) remap <= 1'h1;
        @(posedge clk) remap <= 1'h0;
        @(posedge clk) chk({4'h0, base0}, 16'h00f0);
        cfg(3'h1, 12'h100, 1'h1, 3'h0, 3'h7);
        acc(1'h1, 1'h0, 3'h1);
        chk(lat[15:0], 16'd4);
        chk(wlo[15:0], 16'd2);
        acc(1'h0, 1'h0, 3'h1);
        chk(lat[15:0], 16'd3);
        chk(rdata, 16'h1201 ^ 16'ha5a5);
        acc(1'h0, 1'h0, 3'h1);
        chk(lat[15:0], 16'd3);
        acc(1'h0, 1'h1, 3'h1);
        chk(lat[15:0], 16'd1);
        acc(1'h1, 1'h0, 3'h1);
        chk({15'h0, lat > 3}, 16'h1);
        cfg(3'h1, 12'h100, 1'h1, 3'h3, 3'h0);
        stall <= 4'h3;
        acc(1'h1, 1'h0, 3'h1);
        stall <= 4'h0;
        chk(lat[15:0], 16'd9);
        cfg(3'h1, 12'h100, 1'h1, 3'h0, 3'h0);
        @(posedge clk) {mc_write, rps} <= 2'h3;
        @(posedge clk) mc_write <= 1'h0;
        acc(1'h1, 1'h0, 3'h1);
        chk(lat[15:0], 16'd3);
        acc(1'h0, 1'h0, 3'h1);
        chk(lat[15:0], 16'd4);
        acc(1'h0, 1'h0, 3'h1);
        chk(lat[15:0], 16'd3);
        acc(1'h1, 1'h0, 3'h1);
        chk(lat[15:0], 16'd3);
        chk(wlo[15:0], 16'd2);
        close_out();
    end
endmodule
`default_nettype wire
